/* File: hdl/ssw_pkg.sv */
/*
 * Constants and timing counts shared by the supply supervisor and watchdog.
 * Assumes a single 100 MHz system clock; comparator results arrive as digital levels.
 */
`default_nettype none
package ssw_pkg;
    localparam int unsigned SSW_CLK_HZ = 100_000_000;
    // Stretch time in ms and watchdog timeout in ms (1.56 s).
    localparam int unsigned SSW_STRETCH_MS = 200;
    localparam int unsigned SSW_WDOG_MS = 1560;
    localparam int unsigned SSW_STRETCH_CYC = SSW_STRETCH_MS * (SSW_CLK_HZ / 1000);
    localparam int unsigned SSW_WDOG_CYC = SSW_WDOG_MS * (SSW_CLK_HZ / 1000);
    localparam int unsigned SSW_CNT_W = 32;
    // Synchroniser depth for every pin input.
    localparam int unsigned SSW_SYNC_STAGES = 2;
endpackage
`default_nettype wire

/* File: hdl/ssw_sync.sv */
/*
 * Two-flop level synchroniser for one pin input.
 * Assumes the input is asynchronous to clk_sys; the reset value is a parameter constant.
 */
`default_nettype none
module ssw_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic syncOut
);
    import ssw_pkg::*;

    typedef struct packed {
        logic meta;
        logic stable;
    } ssw_sync_t;

    ssw_sync_t sync_q, sync_d;

    // The first stage feeds only the second stage.
    always_comb begin
        sync_d = sync_q;
        sync_d.meta = pinIn;
        sync_d.stable = sync_q.meta;
    end

    // Both registers settle to the RESET_VAL parameter under reset.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= '{meta: RESET_VAL, stable: RESET_VAL};
        end else begin
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q.stable;
endmodule
`default_nettype wire

/* File: hdl/ssw_supervisor.sv */
/*
 * Supply supervisor with reset stretch, watchdog, supply-fail and low-line outputs.
 * Assumes comparator results as digital levels (1 = above threshold) and one 100 MHz clock.
 * The processor beyond toggles the kick input; wiring the watchdog output to the
 * manual reset input is a board decision outside this module.
 */
`default_nettype none
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter bit ADJUSTABLE = 1'b0,
    parameter int unsigned STRETCH_CYC = ssw_pkg::SSW_STRETCH_CYC,
    parameter int unsigned WDOG_CYC = ssw_pkg::SSW_WDOG_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic manual_reset_in_n,
    input wire logic supply_ok_in,
    input wire logic reset_sense_ok_in,
    input wire logic supply_fail_sense_in,
    input wire logic low_line_ok_in,
    input wire logic watchdog_kick_in,
    output logic reset_out_n,
    output logic reset_out,
    output logic supply_fail_out_n,
    output logic watchdog_expired_out_n,
    output logic low_line_out_n
);
    import ssw_pkg::*;

    // ********************************************************************
    // Parameter checks
    // ********************************************************************
    initial begin
        if (STRETCH_CYC < 2 || WDOG_CYC < 2) begin
            $error("Stretch and watchdog counts must be at least two cycles.");
        end
    end

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    logic mrSync, supplySync, senseSync, failSync, lowLineSync, kickSync;

    // Every pin passes two flops before any logic reads it.
    ssw_sync #(.RESET_VAL(1'b1)) uMr (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(manual_reset_in_n),
        .syncOut(mrSync));
    ssw_sync #(.RESET_VAL(1'b0)) uSup (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(supply_ok_in),
        .syncOut(supplySync));
    ssw_sync #(.RESET_VAL(1'b0)) uSen (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(reset_sense_ok_in),
        .syncOut(senseSync));
    ssw_sync #(.RESET_VAL(1'b0)) uPf (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(supply_fail_sense_in),
        .syncOut(failSync));
    ssw_sync #(.RESET_VAL(1'b0)) uLl (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(low_line_ok_in),
        .syncOut(lowLineSync));
    ssw_sync #(.RESET_VAL(1'b0)) uWd (.clk_sys(clk_sys), .rst_n(rst_n), .pinIn(watchdog_kick_in),
        .syncOut(kickSync));

    // ********************************************************************
    // Reset conditions
    // ********************************************************************
    logic supplyLow, resetCond;

    // The adjustable variant watches its sense input instead of the supply.
    assign supplyLow = ADJUSTABLE ? !senseSync : !supplySync;
    // Manual reset or the comparator starts and holds a reset.
    assign resetCond = supplyLow || !mrSync;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [SSW_CNT_W-1:0] stretchCnt;
        logic [SSW_CNT_W-1:0] wdogCnt;
        logic kickPrev;
        logic wdogExpired;
        logic resetN;
        logic failN;
        logic wdogN;
        logic lowLineN;
    } ssw_state_t;

    ssw_state_t st_q, st_d;

    // One pass computes the stretch timer, watchdog counter and every output.
    always_comb begin
        st_d = st_q;
        st_d.kickPrev = kickSync;
        // Any active condition reloads the stretch so a new brownout restarts it.
        if (resetCond) begin
            st_d.stretchCnt = '0;
            st_d.resetN = 1'b0;
        end else if (st_q.stretchCnt < SSW_CNT_W'(STRETCH_CYC - 1)) begin
            st_d.stretchCnt = st_q.stretchCnt + 1'b1;
            st_d.resetN = 1'b0;
        end else begin
            // Release after the full stretch from the condition ending.
            st_d.resetN = 1'b1;
        end
        // Any edge of the kick input clears the counter.
        if (kickSync != st_q.kickPrev) begin
            st_d.wdogCnt = '0;
            st_d.wdogExpired = 1'b0;
        end else if (st_q.wdogCnt < SSW_CNT_W'(WDOG_CYC - 1)) begin
            st_d.wdogCnt = st_q.wdogCnt + 1'b1;
        end else begin
            // Timeout latches until the next kick edge; the processor must kick in time.
            st_d.wdogExpired = 1'b1;
        end
        // Supply low forces the watchdog output low with no stretch on recovery.
        st_d.wdogN = !(st_d.wdogExpired || supplyLow);
        // Comparator followers, unstretched.
        st_d.failN = failSync;
        st_d.lowLineN = lowLineSync;
    end

    // Reset assumes power just came up: outputs asserted (reset_out high, the rest low), counters cleared.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reset_out_n = st_q.resetN;
    assign reset_out = !st_q.resetN;
    assign supply_fail_out_n = st_q.failN;
    assign watchdog_expired_out_n = st_q.wdogN;
    assign low_line_out_n = st_q.lowLineN;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    property p_mr_asserts;
        @(posedge clk_sys) disable iff (!rst_n)
        !mrSync |=> !reset_out_n;
    endproperty
    a_mr_asserts: assert property (p_mr_asserts) else $error("Manual reset did not assert reset.");

    property p_supply_asserts;
        @(posedge clk_sys) disable iff (!rst_n)
        supplyLow |=> !reset_out_n;
    endproperty
    a_supply_asserts: assert property (p_supply_asserts) else $error("Low supply did not assert reset.");

    property p_sense_source;
        @(posedge clk_sys) disable iff (!rst_n)
        supplyLow == (ADJUSTABLE ? !senseSync : !supplySync);
    endproperty
    a_sense_source: assert property (p_sense_source) else $error("Wrong reset comparator source.");

    property p_release_only_stretched;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(reset_out_n) |-> st_q.stretchCnt == SSW_CNT_W'(STRETCH_CYC - 1) && !$past(resetCond);
    endproperty
    a_release_only_stretched: assert property (p_release_only_stretched)
        else $error("Reset released before full stretch.");

    property p_inverse;
        @(posedge clk_sys) disable iff (!rst_n)
        reset_out == !reset_out_n;
    endproperty
    a_inverse: assert property (p_inverse) else $error("Reset outputs not complementary.");

    property p_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        resetCond |=> st_q.stretchCnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("Stretch not restarted by reset condition.");

    property p_fail_follow;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 supply_fail_out_n == $past(failSync);
    endproperty
    a_fail_follow: assert property (p_fail_follow) else $error("Supply-fail output not following.");

    property p_kick_clears;
        @(posedge clk_sys) disable iff (!rst_n)
        (kickSync != st_q.kickPrev) |=> st_q.wdogCnt == '0 ##1 watchdog_expired_out_n || supplyLow || $past(supplyLow);
    endproperty
    a_kick_clears: assert property (p_kick_clears) else $error("Kick edge did not clear the watchdog.");

    property p_wdog_supply;
        @(posedge clk_sys) disable iff (!rst_n)
        supplyLow |=> !watchdog_expired_out_n;
    endproperty
    a_wdog_supply: assert property (p_wdog_supply) else $error("Watchdog output high with low supply.");

    // Recovery alone must lift the output unless the watchdog has already expired or the counter is about to expire anyway.
    property p_wdog_recover;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(supplyLow) && !st_q.wdogExpired && st_q.wdogCnt < SSW_CNT_W'(WDOG_CYC - 1) |=> watchdog_expired_out_n;
    endproperty
    a_wdog_recover: assert property (p_wdog_recover) else $error("Watchdog output stretched.");

    property p_lowline;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 low_line_out_n == $past(lowLineSync);
    endproperty
    a_lowline: assert property (p_lowline) else $error("Low-line output not following.");

    // A counter at its end with no kick edge must take the output low next cycle.
    property p_wdog_timeout;
        @(posedge clk_sys) disable iff (!rst_n)
        st_q.wdogCnt == SSW_CNT_W'(WDOG_CYC - 1) && kickSync == st_q.kickPrev |=> !watchdog_expired_out_n;
    endproperty
    a_wdog_timeout: assert property (p_wdog_timeout) else $error("Watchdog did not time out.");

    // The end of a manual or supply condition must never release reset at once.
    property p_stretch_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(resetCond) |=> !reset_out_n;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("Reset released without stretch.");

    // Once the stretch is complete and nothing holds reset, the output must be high.
    property p_reset_normal;
        @(posedge clk_sys) disable iff (!rst_n)
        !resetCond && st_q.stretchCnt == SSW_CNT_W'(STRETCH_CYC - 1) |=> reset_out_n;
    endproperty
    a_reset_normal: assert property (p_reset_normal) else $error("Reset low in normal operation.");
endmodule
`default_nettype wire

/* File: testbench/ssw_cpu_model.sv */
/*
 * Behavioural processor model that toggles the watchdog kick pin.
 * Assumes clk_sys and the reset output of the supervisor; halfPeriod is in clock cycles.
 */
`default_nettype none
module ssw_cpu_model (
    input wire logic clk_sys,
    input wire logic reset_out_n,
    input wire logic kickOn,
    input wire logic [15:0] halfPeriod,
    output logic watchdog_kick_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Kick generator
    // ****************************************
    logic [15:0] kickCnt_q;
    initial begin
        kickCnt_q = 16'h0000;
        watchdog_kick_in = 1'b0;
    end
    // A processor held in reset runs no code, so it cannot kick either.
    always @(posedge clk_sys) begin
        if (!kickOn || reset_out_n !== 1'b1) begin
            kickCnt_q <= 16'h0000;
        end else if (kickCnt_q >= halfPeriod - 16'h0001) begin
            kickCnt_q <= 16'h0000;
            watchdog_kick_in <= ~watchdog_kick_in;
        end else begin
            kickCnt_q <= kickCnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/supply_supervisor_watchdog_test.sv */
/*
 * Self-checking bench for the supply supervisor with a processor model on the kick pin.
 * Assumes short stretch and watchdog counts so the run stays brief.
 */
`default_nettype none
module supply_supervisor_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STRETCH = 50;
    localparam int WDOG = 100;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic mrN = 1'b1, supplyOk = 1'b1, failSense = 1'b1, lowLineOk = 1'b1, kickOn = 1'b1;
    logic senseOk = 1'b1;
    logic [15:0] halfPeriod = 16'h0014;
    logic kick, rstN, rstH, failN, wdogN, lowN;
    int mismatches = 0;
    int cmp_count = 0;
    always #5 clk_sys = ~clk_sys;
    ssw_supervisor #(.ADJUSTABLE(1'b0), .STRETCH_CYC(STRETCH), .WDOG_CYC(WDOG)) ssw_supervisor_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .manual_reset_in_n(mrN), .supply_ok_in(supplyOk),
        .reset_sense_ok_in(senseOk), .supply_fail_sense_in(failSense), .low_line_ok_in(lowLineOk),
        .watchdog_kick_in(kick), .reset_out_n(rstN), .reset_out(rstH), .supply_fail_out_n(failN),
        .watchdog_expired_out_n(wdogN), .low_line_out_n(lowN));
    ssw_cpu_model ssw_cpu_model_i (.clk_sys(clk_sys), .reset_out_n(rstN), .kickOn(kickOn),
        .halfPeriod(halfPeriod), .watchdog_kick_in(kick));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // Inputs always move 1 ns after the edge so no race with the design's sampling.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Counts cycles until reset releases, or until the watchdog output falls.
    task automatic waitFor(output int n, input bit onWdog);
        n = 0;
        while ((onWdog ? wdogN !== 1'b0 : rstN !== 1'b1) && n < 300) begin
            cyc(1);
            n++;
        end
        if (n == 300) begin
            mismatches++;
            stop_test();
        end
    endtask
    // The two reset outputs are compared every cycle while rst_n is high, away from the active edge.
    always @(negedge clk_sys) if (rst_n) chk("resetPair", rstH, ~rstN);
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic powerUp;
        int n;
        cyc(20);
        rst_n = 1'b1;
        waitFor(n, 1'b0);
        chk("powerUpStretch", n >= STRETCH && n <= STRETCH + 8, 1'b1);
        chk("failIdle", failN, 1'b1);
    endtask
    // The second dip lands mid-stretch, so only a restarted timer gives the late release.
    task automatic brownout;
        int n;
        supplyOk = 1'b0;
        cyc(4);
        chk("dipReset", rstN, 1'b0);
        chk("dipWdog", wdogN, 1'b0);
        supplyOk = 1'b1;
        cyc(4);
        chk("wdogNoStretch", wdogN, 1'b1);
        chk("resetStretched", rstN, 1'b0);
        cyc(20);
        supplyOk = 1'b0;
        cyc(3);
        supplyOk = 1'b1;
        waitFor(n, 1'b0);
        chk("stretchRestart", n >= STRETCH && n <= STRETCH + 4, 1'b1);
    endtask
    task automatic manualReset;
        int n;
        mrN = 1'b0;
        cyc(4);
        chk("mrAsserts", rstN, 1'b0);
        cyc(30);
        chk("mrHolds", rstN, 1'b0);
        mrN = 1'b1;
        waitFor(n, 1'b0);
        chk("mrStretch", n >= STRETCH && n <= STRETCH + 4, 1'b1);
    endtask
    task automatic comparators;
        failSense = 1'b0;
        cyc(4);
        chk("failLow", failN, 1'b0);
        failSense = 1'b1;
        cyc(4);
        chk("failHigh", failN, 1'b1);
        lowLineOk = 1'b0;
        cyc(4);
        chk("lowLineLow", lowN, 1'b0);
        chk("lowLineNoReset", rstN, 1'b1);
        lowLineOk = 1'b1;
        cyc(4);
        chk("lowLineHigh", lowN, 1'b1);
        // The fixed variant must ignore the adjustable sense input.
        senseOk = 1'b0;
        cyc(4);
        chk("senseIgnored", rstN, 1'b1);
        senseOk = 1'b1;
    endtask
    // Edges every 90 cycles keep it alive only if falling edges clear the count too.
    task automatic watchdog;
        int n;
        logic prev;
        // Reset just ended with no kicks for long; the first kick edge must clear the latched expiry.
        cyc(30);
        chk("kickRestores", wdogN, 1'b1);
        halfPeriod = 16'h005a;
        repeat (6) begin
            cyc(50);
            chk("kickedWdog", wdogN, 1'b1);
        end
        prev = kick;
        n = 0;
        while (kick === prev && n < 200) begin
            cyc(1);
            n++;
        end
        if (n == 200) begin
            mismatches++;
            stop_test();
        end
        kickOn = 1'b0;
        waitFor(n, 1'b1);
        chk("wdogTimeout", n >= WDOG && n <= WDOG + 8, 1'b1);
        cyc(10);
        chk("wdogHeld", wdogN, 1'b0);
        kickOn = 1'b1;
        cyc(100);
        chk("wdogRecover", wdogN, 1'b1);
        // Without the board link from watchdog output to manual reset, expiry leaves reset high.
        chk("wdogNoReset", rstN, 1'b1);
    endtask
    initial begin
        powerUp();
        brownout();
        manualReset();
        comparators();
        watchdog();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
